// [include/csh_pkg.sv]
// Constants and types shared by the character dot shifter design files
package csh_pkg;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CSH_ADDR_STRIKE_ROWS = 8'h00; // Strike-through row mask
    localparam logic [7:0]  CSH_ADDR_STATUS      = 8'h04; // Latched code and attributes
    localparam logic [7:0]  CSH_ADDR_GLYPH_PTR   = 8'h08; // Glyph memory pointer
    localparam logic [7:0]  CSH_ADDR_GLYPH_DATA  = 8'h0c; // Glyph row data, pointer advances

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] CSH_STRIKE_ROWS_RST  = 16'h0060; // Double line on rows 5 and 6
    localparam int          CSH_PTR_W            = 11;       // {code[6:0], row[3:0]}
    localparam int          CSH_GLYPH_W          = 7;        // Columns 0..6 of a glyph row
    localparam int          CSH_GLYPH_DEPTH      = 2048;     // 128 glyphs x 16 rows
    localparam logic [3:0]  CSH_STAT_ATTR_LSB    = 4'h8;     // Attributes start at bit 8

    // ------------------------------------------------------------
    // Graphic geometry
    // ------------------------------------------------------------
    localparam logic [3:0]  CSH_THIN_HROW        = 4'h8;     // Row of the thin horizontal bar
    localparam logic [7:0]  CSH_THIN_VCOL        = 8'h10;    // Column of thin vertical bars

    // ------------------------------------------------------------
    // Display modes, {mode_select_hi, mode_select_lo}
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSH_MODE_ALPHA,
        CSH_MODE_THIN,
        CSH_MODE_EXTERNAL,
        CSH_MODE_WIDE
    } csh_mode_type;

endpackage

// [verilog/csh_glyph_decode.sv]
// Glyph memory and mode dependent decode of one character row
`timescale 1ns/1ns
`default_nettype none
module csh_glyph_decode
    import csh_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 wr_en,
    input  wire logic [CSH_PTR_W-1:0] wr_ptr,
    input  wire logic [6:0]           wr_data,
    input  wire logic [7:0]           code,
    input  wire logic [1:0]           mode,
    input  wire logic [3:0]           row,
    output logic      [7:0]           pattern
);

    // ------------------------------------------------------------
    // Glyph memory, loaded by software
    // ------------------------------------------------------------
    logic [CSH_GLYPH_W-1:0] glyph_mem [0:CSH_GLYPH_DEPTH-1];

    // Store one glyph row per write
    always_ff @(posedge clk) begin
        if (wr_en) begin
            glyph_mem[wr_ptr] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Alphanumeric: low seven code bits pick the glyph, column 7 is blank
    // RL6: top bit ignored
    wire logic [CSH_PTR_W-1:0] rd_ptr     = {code[6:0], row};
    wire logic [7:0]           alpha_bits = {1'h0, glyph_mem[rd_ptr]};
    // Wide graphic: four row bands, each band two half-cell blocks
    // RL8: all eight bits
    wire logic [2:0]           wide_sel   = {row[3:2], 1'h0};
    wire logic [7:0]           wide_bits  = {{4{code[wide_sel + 3'h1]}}, {4{code[wide_sel]}}};
    // Thin graphic: bar and two half-height verticals
    // RL9: three low bits
    wire logic                 thin_h     = code[0] && (row == CSH_THIN_HROW);
    wire logic                 thin_v     = row[3] ? code[2] : code[1];
    wire logic [7:0]           thin_bits  = thin_h ? 8'hff : (thin_v ? CSH_THIN_VCOL : 8'h00);

    // Select by mode
    // RL7: external passes code
    always_comb begin
        case (csh_mode_type'(mode))
            CSH_MODE_ALPHA:    pattern = alpha_bits;
            CSH_MODE_THIN:     pattern = thin_bits;
            CSH_MODE_EXTERNAL: pattern = code;
            CSH_MODE_WIDE:     pattern = wide_bits;
            default:           pattern = 8'h00;
        endcase
    end

endmodule
`default_nettype wire

// [verilog/csh_dot_shifter.sv]
// Character row dot shifter with attribute latch and APB control registers
//
// Functional notes
// RL1: Backfill shifts zero, or one when inverted
// RL2: Each strobe loads next processed character row
// RL3: Strobe low: shift one dot per pulse
// RL4: Strobe high: load on next pulse, no shift
// RL5: Code captured on strobe falling edge
// RL6: Alphanumeric uses low seven code bits
// RL7: External mode passes code word directly
// RL8: Wide graphic uses all eight bits
// RL9: Thin graphic uses three low bits
// RL10: Enable high latches attributes on falling strobe
// RL11: Enable low holds latched attributes
// RL12: Strike-through forces line unless character blank or retrace blank
// RL13: Strike rows from row mask, default 5,6
// RL14: Column seven shifted first, then six..zero
// RL15: Invert attribute inverts parallel data
// RL16: Character blank forces parallel inputs low; the code inverts them to all ones when invert is latched
// RL17: Contents defined after first enabled strobe
`timescale 1ns/1ns
`default_nettype none
module csh_dot_shifter
    import csh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Character side
    input  wire logic        load_shift_strobe,
    input  wire logic        video_shift_clock,
    input  wire logic [7:0]  char_code_in,
    input  wire logic [3:0]  raster_row,
    input  wire logic        attribute_latch_enable,
    input  wire logic        invert_attr,
    input  wire logic        char_blank_attr,
    input  wire logic        underline_attr,
    input  wire logic        strike_through,
    input  wire logic        blink,
    input  wire logic        mode_select_lo,
    input  wire logic        mode_select_hi,
    input  wire logic        retrace_blank,
    output logic             video_out,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]           shift_reg;
    logic [7:0]           code_reg;
    logic                 strobe_prev_reg;
    logic                 inv_reg;
    logic                 blank_reg;
    logic                 under_reg;
    logic                 strike_reg;
    logic                 blink_reg;
    logic [1:0]           mode_reg;
    logic [15:0]          strike_rows_reg;
    logic [CSH_PTR_W-1:0] glyph_ptr_reg;
    logic                 pready_reg;
    logic [31:0]          prdata_reg;
    logic                 pslverr_reg;
    logic [7:0]           pattern;
    logic                 glyph_wr;
    logic [3:0]           fill_cnt_reg;

    // ------------------------------------------------------------
    // Strobe edge and shifter controls
    // ------------------------------------------------------------
    // Falling strobe found against its copy from the previous clock
    wire logic       strobe_fall = strobe_prev_reg && !load_shift_strobe;
    wire logic       attr_take   = strobe_fall && attribute_latch_enable;
    wire logic       do_load     = video_shift_clock && load_shift_strobe;
    wire logic       do_shift    = video_shift_clock && !load_shift_strobe;
    wire logic       strike_row  = strike_rows_reg[raster_row];
    // Backfill follows the latched invert flag, never the live pin
    wire logic       backfill    = inv_reg;
    wire logic [7:0] attr_data;
    wire logic [7:0] par_in;

    // Row decode for the latched code and mode
    csh_glyph_decode u_decode (
        .clk     (clk),
        .wr_en   (glyph_wr),
        .wr_ptr  (glyph_ptr_reg),
        .wr_data (pwdata[6:0]),
        .code    (code_reg),
        .mode    (mode_reg),
        .row     (raster_row),
        .pattern (pattern)
    );

    // RL12: strike line overlay
    // RL13: row mask picks rows
    // RL16: blanking wins over pattern
    assign attr_data = blank_reg ? 8'h00 :
                       ((strike_reg && strike_row) ? 8'hff : pattern);
    // RL15: optional inversion
    // RL14: column seven inverted too
    assign par_in    = retrace_blank ? 8'h00 : (inv_reg ? ~attr_data : attr_data);

    // Dots leave from bit 7, the first column shifted; the output is a
    // straight copy of that flip-flop, so it only moves on a pulse
    assign video_out = shift_reg[7];

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    // A load wins over a shift; extra pulses while high reload
    // RL2: load then shift
    // RL4: load suppresses shifting
    // RL3: one dot per pulse
    // RL1: backfill enters bit 0
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
        end else if (do_load) begin
            shift_reg <= par_in;
        end else if (do_shift) begin
            shift_reg <= {shift_reg[6:0], backfill};
        end
    end

    // ------------------------------------------------------------
    // Code and attribute latches
    // ------------------------------------------------------------
    // RL5: code on falling strobe
    // RL17: defined by reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_prev_reg <= 1'h0;
            code_reg        <= 8'h00;
        end else begin
            strobe_prev_reg <= load_shift_strobe;
            if (strobe_fall) begin
                code_reg <= char_code_in;
            end
        end
    end

    // Underline and blink are latched for status only
    // RL10: enabled attribute capture
    // RL11: hold while disabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inv_reg    <= 1'h0;
            blank_reg  <= 1'h0;
            under_reg  <= 1'h0;
            strike_reg <= 1'h0;
            blink_reg  <= 1'h0;
            mode_reg   <= 2'h0;
        end else if (attr_take) begin
            inv_reg    <= invert_attr;
            blank_reg  <= char_blank_attr;
            under_reg  <= underline_attr;
            strike_reg <= strike_through;
            blink_reg  <= blink;
            mode_reg   <= {mode_select_hi, mode_select_lo};
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    wire logic        apb_access = psel && penable;
    wire logic        apb_done   = apb_access && pready_reg;
    wire logic        hit_rows   = (paddr == CSH_ADDR_STRIKE_ROWS);
    wire logic        hit_stat   = (paddr == CSH_ADDR_STATUS);
    wire logic        hit_ptr    = (paddr == CSH_ADDR_GLYPH_PTR);
    wire logic        hit_data   = (paddr == CSH_ADDR_GLYPH_DATA);
    wire logic        hit_any    = hit_rows || hit_stat || hit_ptr || hit_data;
    wire logic [5:0]  attr_vec   = {mode_reg, blink_reg, strike_reg, under_reg, blank_reg};
    wire logic [31:0] stat_word  = {17'h00000, attr_vec, inv_reg, code_reg};
    wire logic [31:0] rd_mux     = hit_rows ? {16'h0000, strike_rows_reg} :
                                   hit_stat ? stat_word :
                                   hit_ptr  ? {21'h000000, glyph_ptr_reg} : 32'h00000000;
    // Glyph memory write strobe at the completing edge
    assign glyph_wr = apb_done && pwrite && hit_data;

    // Handshake and read data; prdata and pslverr are registered
    // together with pready, so they stand for exactly that one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_reg  <= 1'h0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'h0;
        end else begin
            pready_reg  <= apb_access && !pready_reg;
            prdata_reg  <= (apb_access && !pready_reg && !pwrite) ? rd_mux : 32'h00000000;
            pslverr_reg <= apb_access && !pready_reg && !hit_any;
        end
    end

    // Control registers written at the completing edge
    // The pointer steps after each data write so glyph rows can be streamed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strike_rows_reg <= CSH_STRIKE_ROWS_RST;
            glyph_ptr_reg   <= '0;
        end else if (apb_done && pwrite) begin
            if (hit_rows) begin
                strike_rows_reg <= pwdata[15:0];
            end
            if (hit_ptr) begin
                glyph_ptr_reg <= pwdata[CSH_PTR_W-1:0];
            end else if (hit_data) begin
                glyph_ptr_reg <= glyph_ptr_reg + 11'h001;
            end
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Assertion helper
    // ------------------------------------------------------------
    // Dots shifted since the last load or attribute capture; at eight
    // every bit was filled with the invert flag that is latched now
    always_ff @(posedge clk) begin
        if (!rst_n || do_load || attr_take) begin
            fill_cnt_reg <= 4'h0;
        end else if (do_shift && fill_cnt_reg != 4'h8) begin
            fill_cnt_reg <= fill_cnt_reg + 4'h1;
        end
    end

    property p_load;
        do_load |=> (shift_reg == $past(par_in));
    endproperty
    // RL4: load takes parallel data
    a_load: assert property (p_load) else $error("parallel load missed"); // RL4

    property p_shift;
        do_shift |=> (shift_reg == {$past(shift_reg[6:0]), $past(inv_reg)});
    endproperty
    // RL3: one position per pulse
    a_shift: assert property (p_shift) else $error("serial shift wrong"); // RL3

    property p_idle;
        !video_shift_clock |=> $stable(shift_reg);
    endproperty
    // RL3: no pulse, no motion
    a_idle: assert property (p_idle) else $error("shifter moved without pulse"); // RL3

    property p_fill;
        (fill_cnt_reg == 4'h8) |-> (shift_reg == {8{inv_reg}});
    endproperty
    // RL1: backfill after eight dots
    a_fill: assert property (p_fill) else $error("backfill value wrong"); // RL1

    property p_code;
        strobe_fall |=> (code_reg == $past(char_code_in));
    endproperty
    // RL5: code capture
    a_code: assert property (p_code) else $error("code not captured"); // RL5

    property p_attr;
        attr_take |=> (inv_reg == $past(invert_attr)) && (mode_reg[1] == $past(mode_select_hi))
                      && (mode_reg[0] == $past(mode_select_lo));
    endproperty
    // RL10: attribute capture
    a_attr: assert property (p_attr) else $error("attributes not latched"); // RL10

    property p_hold;
        !attr_take |=> $stable(attr_vec) && $stable(inv_reg);
    endproperty
    // RL11: attributes held
    a_hold: assert property (p_hold) else $error("attributes changed while held"); // RL11

    property p_blank;
        (blank_reg && !retrace_blank) |-> (par_in == {8{inv_reg}});
    endproperty
    // RL16: blank forces low, or all ones when inverted
    a_blank: assert property (p_blank) else $error("blank not applied"); // RL16

    property p_strike;
        (strike_reg && !blank_reg && !retrace_blank && strike_row) |-> (par_in == {8{!inv_reg}});
    endproperty
    // RL12: strike forces high, or all zeros when inverted
    a_strike: assert property (p_strike) else $error("strike line not applied"); // RL12

    property p_c7;
        (mode_reg == 2'h0 && !strike_reg && !blank_reg && !retrace_blank)
            |-> (par_in[7] == inv_reg);
    endproperty
    // RL14: column seven value
    a_c7: assert property (p_c7) else $error("column seven wrong"); // RL14

    property p_retrace;
        (do_load && retrace_blank) |=> (shift_reg == 8'h00);
    endproperty
    // RL12: retrace loads blank
    a_retrace: assert property (p_retrace) else $error("retrace blank not loaded"); // RL12

    property p_plain;
        (do_load && !inv_reg && !retrace_blank && !blank_reg && !(strike_reg && strike_row))
            |-> (par_in == pattern);
    endproperty
    // RL15: data passes unchanged
    a_plain: assert property (p_plain) else $error("plain data altered"); // RL15

    property p_invert;
        (do_load && inv_reg && !retrace_blank && !blank_reg && !(strike_reg && strike_row))
            |-> (par_in == ~pattern);
    endproperty
    // RL15: data inverted
    a_invert: assert property (p_invert) else $error("inverted data wrong"); // RL15

    property p_code_hold;
        !strobe_fall |=> $stable(code_reg);
    endproperty
    // RL5: code held between falls
    a_code_hold: assert property (p_code_hold) else $error("code changed without fall"); // RL5

    property p_rows;
        (apb_done && pwrite && hit_rows) |=> (strike_rows_reg == $past(pwdata[15:0]));
    endproperty
    // RL13: row mask written
    a_rows: assert property (p_rows) else $error("strike row mask not written"); // RL13

    c_load_inv:   cover property (do_load && inv_reg);
    c_strike:     cover property (do_load && strike_reg && strike_row);
    c_glyph_wr:   cover property (glyph_wr);
    c_attr_held:  cover property (strobe_fall && !attribute_latch_enable);
    c_backfill:   cover property (fill_cnt_reg == 4'h8 && inv_reg);

endmodule
`default_nettype wire

// [sim/csh_ctrl_model.sv]
// Display controller and character memory model feeding the dot shifter
`timescale 1ns/1ns
`default_nettype none
module csh_ctrl_model (
    input  wire logic       clk,
    input  wire logic       video_out,
    output var logic        load_shift_strobe,
    output var logic        video_shift_clock,
    output var logic [7:0]  char_code_in,
    output var logic [3:0]  raster_row
);
    // Idle levels at time zero
    initial begin
        load_shift_strobe = 1'h0;
        video_shift_clock = 1'h0;
        char_code_in      = 8'h00;
        raster_row        = 4'h0;
    end

    // --------------------------------------------------------
    // One character row, n dots collected, gap + 1 cycles apart
    // --------------------------------------------------------
    task automatic show_char(input logic [7:0] c, input logic [3:0] r, input int gap,
                             input int n, output logic [15:0] dots);
        int k;
        dots = 16'h0000;
        char_code_in      <= c;
        raster_row        <= r;
        load_shift_strobe <= 1'h1;
        @(posedge clk);
        load_shift_strobe <= 1'h0;
        @(posedge clk);
        load_shift_strobe <= 1'h1;
        @(posedge clk);
        video_shift_clock <= 1'h1;
        @(posedge clk);
        video_shift_clock <= 1'h0;
        load_shift_strobe <= 1'h0;
        for (k = 0; k < n; k++) begin
            repeat (gap) @(posedge clk);
            dots[15-k] = video_out;
            char_code_in      <= ~c; // Code lines no longer valid once latched
            video_shift_clock <= 1'h1;
            @(posedge clk);
            video_shift_clock <= 1'h0;
        end
    endtask
endmodule
`default_nettype wire

// [sim/csh_dot_shifter_tb_top.sv]
// Self-checking bench for the character dot shifter
`timescale 1ns/1ns
`default_nettype none
module csh_dot_shifter_tb_top
    import csh_pkg::*;
    ;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        load_shift_strobe, video_shift_clock, video_out;
    logic [7:0]  char_code_in;
    logic [3:0]  raster_row;
    logic        attribute_latch_enable = 1'h0, invert_attr = 1'h0, char_blank_attr = 1'h0;
    logic        underline_attr = 1'h0, strike_through = 1'h0, blink = 1'h0;
    logic        mode_select_lo = 1'h0, mode_select_hi = 1'h0, retrace_blank = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        e;
    logic [15:0] dots, smask = CSH_STRIKE_ROWS_RST;
    logic [1:0]  lat_m = 2'h0;
    logic [2:0]  lat_a = 3'h0; // Latched {invert, blank, strike}
    logic [6:0]  glyph_row = 7'h5a;
    int          fails = 0;
    int          samples_checked = 0;
    int          i;

    always #10 clk = ~clk;

    csh_dot_shifter i_dut (.clk, .rst_n, .load_shift_strobe, .video_shift_clock,
        .char_code_in, .raster_row, .attribute_latch_enable, .invert_attr,
        .char_blank_attr, .underline_attr, .strike_through, .blink, .mode_select_lo,
        .mode_select_hi, .retrace_blank, .video_out, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr);

    csh_ctrl_model i_ctrl (.clk, .video_out, .load_shift_strobe, .video_shift_clock,
        .char_code_in, .raster_row);

    // --------------------------------------------------------
    // Compare, report and bus tasks
    // --------------------------------------------------------
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_dots(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // APB transfer, answer taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int t;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (t = 0; t < 50; t++) begin
            @(posedge clk);
            if (pready === 1'h1) begin
                break;
            end
        end
        rd  = prdata;
        err = pslverr;
        if (t == 50) begin
            fails++;
            tally_and_finish();
        end
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // Drive attributes, show one row, compare dots with the expected row
    task automatic run(input logic [1:0] m, input logic [7:0] c, input logic [3:0] r,
                       input logic [4:0] a, input int gap, input int n);
        logic [7:0]  p;
        logic [15:0] x;
        {attribute_latch_enable, invert_attr, char_blank_attr, strike_through,
         retrace_blank} <= a;
        {mode_select_hi, mode_select_lo} <= m;
        if (a[4]) begin
            lat_m = m;
            lat_a = a[3:1];
        end
        case (lat_m)
            CSH_MODE_ALPHA:    p = {1'h0, glyph_row};
            CSH_MODE_THIN:     p = ((c[0] && r == CSH_THIN_HROW) ? 8'hff : 8'h00)
                                 | (((c[1] && r < 4'h8) || (c[2] && r >= 4'h8)) ?
                                    CSH_THIN_VCOL : 8'h00);
            CSH_MODE_EXTERNAL: p = c;
            default:           p = {{4{c[{r[3:2], 1'h1}]}}, {4{c[{r[3:2], 1'h0}]}}};
        endcase
        if (lat_a[1]) begin
            p = 8'h00;
        end else if (lat_a[0] && smask[r]) begin
            p = 8'hff;
        end
        if (lat_a[2]) begin
            p = ~p;
        end
        if (a[0]) begin
            p = 8'h00;
        end
        x = {p, {8{lat_a[2]}}} & ~(16'hffff >> n);
        i_ctrl.show_char(c, r, gap, n, dots);
        check_dots("dots", x, dots & ~(16'hffff >> n));
    endtask

    // --------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, CSH_ADDR_STRIKE_ROWS, 32'h0, q, e);
        check_word("strike_rows", 32'h0000_0060, q);
        apb(1'h0, CSH_ADDR_STATUS, 32'h0, q, e);
        check_word("status", 32'h0, q);
        apb(1'h1, 8'h10, 32'hffff_ffff, q, e);
        check_word("unmapped_err", 32'h1, {31'h0, e});
        apb(1'h0, 8'h10, 32'h0, q, e);
        check_word("unmapped_data", 32'h0, q);
        end_test("registers");
        apb(1'h1, CSH_ADDR_GLYPH_PTR, {21'h0, 7'h45, 4'h3}, q, e);
        apb(1'h1, CSH_ADDR_GLYPH_DATA, {25'h0, glyph_row}, q, e);
        apb(1'h0, CSH_ADDR_GLYPH_PTR, 32'h0, q, e);
        check_word("glyph_ptr", 32'h0000_0454, q);
        run(CSH_MODE_ALPHA, 8'hc5, 4'h3, 5'h10, 3, 12);
        end_test("alpha");
        for (i = 0; i < 4; i++) begin
            run(CSH_MODE_EXTERNAL, 8'h81 ^ (8'h3c << i), 4'h0, 5'h10, 2 + i, 9 + i);
        end
        for (i = 0; i < 4; i++) begin
            run(CSH_MODE_WIDE, 8'h9c, {i[1:0], 2'h1}, 5'h10, 2, 8);
        end
        run(CSH_MODE_THIN, 8'hf9, CSH_THIN_HROW, 5'h10, 2, 8);
        run(CSH_MODE_THIN, 8'h02, 4'h3, 5'h10, 2, 8);
        run(CSH_MODE_THIN, 8'h02, 4'hc, 5'h10, 2, 8);
        run(CSH_MODE_THIN, 8'h04, 4'hc, 5'h10, 2, 8);
        end_test("modes");
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h0, 5'h18, 3, 14);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h0, 5'h14, 2, 10);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h0, 5'h1c, 2, 10);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h5, 5'h12, 2, 8);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h4, 5'h12, 2, 8);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h6, 5'h13, 2, 8);
        apb(1'h1, CSH_ADDR_STRIKE_ROWS, 32'h0000_0010, q, e);
        check_word("rows_err", 32'h0, {31'h0, e});
        apb(1'h0, CSH_ADDR_STRIKE_ROWS, 32'h0, q, e);
        check_word("strike_rows", 32'h0000_0010, q);
        smask = 16'h0010;
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h4, 5'h12, 2, 8);
        run(CSH_MODE_EXTERNAL, 8'h81, 4'h5, 5'h12, 2, 8);
        end_test("attributes");
        underline_attr <= 1'h1;
        blink          <= 1'h1;
        run(CSH_MODE_EXTERNAL, 8'h3c, 4'h2, 5'h18, 2, 10);
        underline_attr <= 1'h0;
        blink          <= 1'h0;
        run(CSH_MODE_WIDE, 8'h66, 4'h2, 5'h00, 2, 10);
        apb(1'h0, CSH_ADDR_STATUS, 32'h0, q, e);
        check_word("status", {17'h0, 2'h2, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 8'h66}, q);
        end_test("latch_hold");
        tally_and_finish();
    end
endmodule
`default_nettype wire
